// >>> csfu_pkg.sv
// Package with the register map, flag layout, opcodes and carriers of the status flag unit
`default_nettype none
package csfu_pkg;
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 32;
	localparam int          FLAG_W      = 8;
	localparam int          EVT_W       = 3;
	localparam logic [3:0]  REG_FLAGS   = 4'h0;
	localparam logic [3:0]  REG_EVT_ST  = 4'h4;
	localparam logic [3:0]  REG_EVT_CLR = 4'h8;
	localparam logic [3:0]  REG_EVT_EN  = 4'hC;
	localparam logic [7:0]  FLAGS_RST   = 8'h00;
	localparam logic [7:0]  SW_MASK     = 8'hCF;
	localparam logic [2:0]  EVT_RST     = 3'h0;
	localparam int          EVT_WDT     = 0;
	localparam int          EVT_HALT    = 1;
	localparam int          EVT_WRAP    = 2;
	localparam int          MSB         = 7;
	localparam int          NIB         = 4;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_ADD,
		OP_ADD_CARRY,
		OP_SUB,
		OP_SUBTRACT_WITH_BORROW,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_ROT_RIGHT_CARRY,
		OP_ROT_LEFT_CARRY,
		OP_WATCHDOG_CLEAR,
		OP_HALT,
		OP_CALL,
		OP_INT_ENTRY
	} csfu_op_e;

	typedef struct packed {
		logic       valid;
		csfu_op_e   op;
		logic [7:0] a;
		logic [7:0] b;
	} csfu_instr_s;

	// Field order matches the bit layout 7..0 of the condition flag register
	typedef struct packed {
		logic signed_result_flag;
		logic chained_zero_flag;
		logic wdt_expired_flag;
		logic halt_entered_flag;
		logic twos_complement_wrap_flag;
		logic zero_flag;
		logic nibble_carry_flag;
		logic carry_flag;
	} csfu_flags_s;
endpackage : csfu_pkg
`default_nettype wire

// >>> csfu_flag_calc.sv
// Combinational result and arithmetic flag computation for one instruction
`timescale 1ns/1ps
`default_nettype none
module csfu_flag_calc (
	input  wire csfu_pkg::csfu_instr_s instr,
	input  wire csfu_pkg::csfu_flags_s cur,
	output logic [7:0]                 result,
	output csfu_pkg::csfu_flags_s      calc,
	output logic [7:0]                 upd
);
	import csfu_pkg::*;

	wire       is_sub   = (instr.op == OP_SUB) || (instr.op == OP_SUBTRACT_WITH_BORROW);
	wire       is_add   = (instr.op == OP_ADD) || (instr.op == OP_ADD_CARRY);
	wire       is_logic = (instr.op == OP_AND) || (instr.op == OP_OR) || (instr.op == OP_XOR);
	wire [7:0] opb      = is_sub ? ~instr.b : instr.b;
	// Subtract is add of the inverted operand, so carry out means no borrow
	wire       cin      = (instr.op == OP_SUB) ? 1'b1 :
	                      ((instr.op == OP_ADD_CARRY) ||
	                       (instr.op == OP_SUBTRACT_WITH_BORROW)) ? cur.carry_flag : 1'b0;
	wire [8:0] sum      = {1'b0, instr.a} + {1'b0, opb} + {8'h00, cin};
	wire [4:0] low_sum  = {1'b0, instr.a[NIB-1:0]} + {1'b0, opb[NIB-1:0]} + {4'h0, cin};
	wire [7:0] msb_in   = {1'b0, instr.a[MSB-1:0]} + {1'b0, opb[MSB-1:0]} + {7'h00, cin};
	wire       wrap     = msb_in[MSB] ^ sum[MSB+1];

	always_comb begin
		result = instr.a;
		calc   = cur;
		upd    = 8'h00;
		case (instr.op)
			OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
				result                         = sum[MSB:0];
				calc.carry_flag                = sum[MSB+1];
				calc.nibble_carry_flag         = low_sum[NIB];
				calc.zero_flag                 = (sum[MSB:0] == 8'h00);
				calc.twos_complement_wrap_flag = wrap;
				calc.signed_result_flag        = wrap ^ sum[MSB];
				// Borrow chain keeps zero across a multi-byte subtract
				calc.chained_zero_flag = (instr.op == OP_SUBTRACT_WITH_BORROW) ?
				                         (cur.chained_zero_flag & (sum[MSB:0] == 8'h00)) :
				                         (sum[MSB:0] == 8'h00);
				upd = SW_MASK;
			end
			OP_AND, OP_OR, OP_XOR: begin
				result = (instr.op == OP_AND) ? (instr.a & instr.b) :
				         (instr.op == OP_OR)  ? (instr.a | instr.b) : (instr.a ^ instr.b);
				calc.zero_flag = (result == 8'h00);
				upd            = 8'h04;
			end
			OP_ROT_RIGHT_CARRY: begin
				result          = {cur.carry_flag, instr.a[MSB:1]};
				calc.carry_flag = instr.a[0];
				upd             = 8'h01;
			end
			OP_ROT_LEFT_CARRY: begin
				result          = {instr.a[MSB-1:0], cur.carry_flag};
				calc.carry_flag = instr.a[MSB];
				upd             = 8'h01;
			end
			default: begin
				result = instr.a;
			end
		endcase
	end

	wire unused_ok = is_add | is_logic;
endmodule : csfu_flag_calc
`default_nettype wire

// >>> csfu_top.sv
// Status flag unit of the core with its register slave and event interrupt
//
// Overview of operation
// - Software writes never change the watchdog-expired or halt-entered flags.
// - Other flag bits are software writable and normally follow the latest operation.
// - Watchdog-expired clears on reset, watchdog clear, halt; sets on watchdog timeout.
// - Halt-entered clears on reset or watchdog clear, sets on halt only.
// - Carry sets on add carry-out or subtract without borrow, else clears.
// - Rotates through carry move old carry in and shifted-out bit to carry.
// - Nibble carry sets on low-nibble carry or no nibble borrow, else clears.
// - Zero flag follows whether an arithmetic or logical result is zero.
// - Wrap flag is carry into bit 7 differing from carry out.
// - Signed-result flag is wrap flag xor result bit 7.
// - Chained-zero flag combines flags depending on the instruction.
// - Calls and interrupt entry leave the flag register untouched.
`timescale 1ns/1ps
`default_nettype none
module csfu_top (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [3:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [3:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire csfu_pkg::csfu_instr_s instr,
	input  wire logic                  wdt_timeout,
	output logic [7:0]                 alu_result,
	output csfu_pkg::csfu_flags_s      flags,
	output logic                       irq
);
	import csfu_pkg::*;

	logic [3:0]       aw_addr;
	logic             aw_hold;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             w_hold;
	logic [EVT_W-1:0] evt_status;
	logic [EVT_W-1:0] evt_enable;
	logic [7:0]       calc_result;
	logic [7:0]       calc_upd;
	csfu_flags_s      calc_flags;
	csfu_flags_s      next_flags;

	csfu_flag_calc u_calc (
		.instr  (instr),
		.cur    (flags),
		.result (calc_result),
		.calc   (calc_flags),
		.upd    (calc_upd)
	);

	// Write side: address and data are caught separately, committed together
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	wire   do_write      = aw_hold && w_hold && !s_axi_bvalid;
	wire   wr_lane0      = do_write && w_strb[0];
	wire   wr_flags      = wr_lane0 && (aw_addr == REG_FLAGS);
	wire   wr_clr        = wr_lane0 && (aw_addr == REG_EVT_CLR);
	wire   wr_en         = wr_lane0 && (aw_addr == REG_EVT_EN);
	wire   aw_mapped     = (aw_addr == REG_FLAGS) || (aw_addr == REG_EVT_ST) ||
	                       (aw_addr == REG_EVT_CLR) || (aw_addr == REG_EVT_EN);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			aw_addr <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_hold <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_hold <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read side: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;
	wire   ar_mapped     = (s_axi_araddr == REG_FLAGS) || (s_axi_araddr == REG_EVT_ST) ||
	                       (s_axi_araddr == REG_EVT_CLR) || (s_axi_araddr == REG_EVT_EN);
	// Clear register is write-only and reads back as zero
	wire [31:0] rd_mux   = (s_axi_araddr == REG_FLAGS)  ? {24'h000000, flags} :
	                       (s_axi_araddr == REG_EVT_ST) ? {29'h00000000, evt_status} :
	                       (s_axi_araddr == REG_EVT_EN) ? {29'h00000000, evt_enable} :
	                       RDATA_ZERO;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= RDATA_ZERO;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Flag register; a bus write wins over an instruction update in the same cycle
	wire [7:0] sw_sel  = wr_flags ? SW_MASK : 8'h00;
	wire [7:0] alu_sel = instr.valid ? (calc_upd & SW_MASK & ~sw_sel) : 8'h00;
	wire [7:0] keep    = ~sw_sel & ~alu_sel & SW_MASK;
	// Call and interrupt entry raise no update mask, so the flags simply stay
	wire [7:0] arith   = (w_data[7:0] & sw_sel) | (calc_flags & alu_sel) | (flags & keep);
	wire is_wclr = instr.valid && (instr.op == OP_WATCHDOG_CLEAR);
	wire is_halt = instr.valid && (instr.op == OP_HALT);

	always_comb begin
		next_flags = csfu_flags_s'(arith);
		// Timeout set wins over a clear in the same cycle
		next_flags.wdt_expired_flag  = wdt_timeout ? 1'b1 :
		                               (is_wclr || is_halt) ? 1'b0 : flags.wdt_expired_flag;
		next_flags.halt_entered_flag = is_halt ? 1'b1 :
		                               is_wclr ? 1'b0 : flags.halt_entered_flag;
	end

	// Power-up is the reset; arithmetic bits are undefined then, so zero is chosen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= csfu_flags_s'(FLAGS_RST);
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alu_result <= 8'h00;
		end else if (instr.valid) begin
			alu_result <= calc_result;
		end
	end

	// Events: watchdog timeout, halt entry, arithmetic wrap; set wins over clear
	wire [EVT_W-1:0] evt_set = {alu_sel[3] & calc_flags.twos_complement_wrap_flag,
	                            is_halt, wdt_timeout};
	wire [EVT_W-1:0] evt_clr = wr_clr ? w_data[EVT_W-1:0] : EVT_RST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_status <= EVT_RST;
			evt_enable <= EVT_RST;
		end else begin
			evt_status <= (evt_status & ~evt_clr) | evt_set;
			if (wr_en) begin
				evt_enable <= w_data[EVT_W-1:0];
			end
		end
	end

	assign irq = |(evt_status & evt_enable);

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire [8:0] chk_add = {1'b0, instr.a} + {1'b0, instr.b};
	wire       alu_arith = instr.valid && !wr_flags && ((instr.op == OP_ADD) ||
	                       (instr.op == OP_SUB) || (instr.op == OP_SUBTRACT_WITH_BORROW));

	property p_sw_keeps_sys;
		wr_flags && !instr.valid && !wdt_timeout |=>
			$stable(flags.wdt_expired_flag) && $stable(flags.halt_entered_flag);
	endproperty
	a_sw_keeps_sys: assert property (p_sw_keeps_sys) else $error("system flag changed by write");

	property p_sw_write;
		wr_flags |=> (flags & SW_MASK) == ($past(w_data[7:0]) & SW_MASK);
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("flag write not stored");

	property p_wdt_set;
		wdt_timeout |=> flags.wdt_expired_flag;
	endproperty
	a_wdt_set: assert property (p_wdt_set) else $error("timeout did not set flag");

	property p_wdt_clear;
		(is_wclr || is_halt) && !wdt_timeout |=> !flags.wdt_expired_flag;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("expired flag not cleared");

	property p_halt_flag;
		!is_halt && !is_wclr |=> $stable(flags.halt_entered_flag);
	endproperty
	a_halt_flag: assert property (p_halt_flag) else $error("halt flag changed");

	property p_halt_set;
		is_halt ##1 !is_wclr |-> flags.halt_entered_flag ##0 !$past(is_wclr);
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("halt flag not set");

	property p_add_carry;
		alu_arith && instr.op == OP_ADD |=>
			flags.carry_flag == $past(chk_add[8]) && alu_result == $past(chk_add[7:0]);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_sub_carry;
		alu_arith && instr.op == OP_SUB |=>
			flags.carry_flag == ($past(instr.a) >= $past(instr.b));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

	property p_zero;
		alu_arith |=> flags.zero_flag == (alu_result == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_signed;
		alu_arith |=> flags.signed_result_flag ==
			(flags.twos_complement_wrap_flag ^ alu_result[MSB]);
	endproperty
	a_signed: assert property (p_signed) else $error("signed result wrong");

	property p_chain;
		alu_arith && instr.op == OP_SUBTRACT_WITH_BORROW |=>
			flags.chained_zero_flag == ($past(flags.chained_zero_flag) && flags.zero_flag);
	endproperty
	a_chain: assert property (p_chain) else $error("chained zero wrong");

	property p_call_keeps;
		instr.valid && (instr.op == OP_CALL || instr.op == OP_INT_ENTRY) && !wr_flags
			|=> (flags & SW_MASK) == ($past(flags) & SW_MASK);
	endproperty
	a_call_keeps: assert property (p_call_keeps) else $error("call touched flags");

	c_sub_chain: cover property (alu_arith && instr.op == OP_SUBTRACT_WITH_BORROW
		##1 flags.chained_zero_flag);
	c_wdt_irq: cover property (wdt_timeout ##1 irq);
	c_write_resp: cover property (do_write ##1 s_axi_bvalid);
	c_halt_then_clear: cover property (is_halt ##[1:20] is_wclr);
endmodule : csfu_top
`default_nettype wire

// >>> csfu_core_model.sv
// Behavioural model of the core datapath that issues instructions to the flag unit
`timescale 1ns/1ps
`default_nettype none
module csfu_core_model (
	input  wire logic                aclk,
	output var csfu_pkg::csfu_instr_s instr,
	output logic                     wdt_timeout
);
	import csfu_pkg::*;

	initial begin
		instr       = '0;
		wdt_timeout = 1'b0;
	end

	// One instruction for one cycle; operands are scrambled once released so stale values never look valid
	task automatic issue(input csfu_op_e op, input logic [7:0] a, input logic [7:0] b, input logic to);
		@(posedge aclk);
		instr       <= '{valid: 1'b1, op: op, a: a, b: b};
		wdt_timeout <= to;
		@(posedge aclk);
		instr.valid <= 1'b0;
		instr.a     <= ~a;
		instr.b     <= ~b;
		wdt_timeout <= 1'b0;
	endtask : issue
endmodule : csfu_core_model
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the status flag unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import csfu_pkg::*;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic        awready, wready, bvalid, arready, rvalid, irq, wdt_timeout;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  alu_result, ef;
	logic [2:0]  evt, en;
	csfu_flags_s flags;
	csfu_instr_s instr;
	logic [31:0] seed = 32'h67CF;
	int          fails = 0, samples_checked = 0;
	csfu_op_e    opt[12] = '{OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_AND,
		OP_OR, OP_XOR, OP_ROT_RIGHT_CARRY, OP_ROT_LEFT_CARRY, OP_CALL, OP_INT_ENTRY};
	csfu_op_e    dop[9] = '{OP_ADD, OP_SUB, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_ADD, OP_SUB,
		OP_ROT_LEFT_CARRY, OP_ROT_RIGHT_CARRY, OP_INT_ENTRY};
	logic [7:0]  da[9] = '{8'hFF, 8'h00, 8'h05, 8'h10, 8'h7F, 8'h80, 8'h80, 8'h01, 8'h00};
	logic [7:0]  db[9] = '{8'h01, 8'h01, 8'h05, 8'h0F, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

	always #10 aclk = ~aclk;

	csfu_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.instr(instr), .wdt_timeout(wdt_timeout), .alu_result(alu_result), .flags(flags), .irq(irq));

	csfu_core_model i_core (.aclk(aclk), .instr(instr), .wdt_timeout(wdt_timeout));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Expected {result, flags} of one instruction from the previous flags
	function automatic logic [15:0] model(input csfu_op_e op, input logic [7:0] a, b, f);
		logic [8:0] s;
		logic [7:0] bb, r, nf, m;
		logic [4:0] n;
		logic       ci;
		r  = a;
		nf = f;
		bb = (op inside {OP_SUB, OP_SUBTRACT_WITH_BORROW}) ? ~b : b;
		ci = (op == OP_SUB) ? 1'b1 : ((op == OP_ADD) ? 1'b0 : f[0]);
		s  = a + bb + ci;
		n  = a[3:0] + bb[3:0] + ci;
		m  = a[6:0] + bb[6:0] + ci;
		case (op)
			OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
				r     = s[7:0];
				nf[0] = s[8];
				nf[1] = n[4];
				nf[2] = (r == 8'h00);
				nf[3] = m[7] ^ s[8];
				nf[7] = nf[3] ^ r[7];
				nf[6] = (op == OP_SUBTRACT_WITH_BORROW) ? (f[6] & nf[2]) : nf[2];
			end
			OP_AND: r = a & b;
			OP_OR: r = a | b;
			OP_XOR: r = a ^ b;
			OP_ROT_RIGHT_CARRY: begin
				r     = {f[0], a[7:1]};
				nf[0] = a[0];
			end
			OP_ROT_LEFT_CARRY: begin
				r     = {a[6:0], f[0]};
				nf[0] = a[7];
			end
			OP_WATCHDOG_CLEAR: nf[5:4] = 2'b00;
			OP_HALT: nf[5:4] = 2'b01;
			default: ;
		endcase
		if (op inside {OP_AND, OP_OR, OP_XOR})
			nf[2] = (r == 8'h00);
		return {r, nf};
	endfunction : model

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic step(input csfu_op_e op, input logic [7:0] a, b, input logic to);
		logic [15:0] m;
		m = model(op, a, b, ef);
		if (to)
			m[5] = 1'b1;
		evt[0] = evt[0] | to;
		evt[1] = evt[1] | (op == OP_HALT);
		evt[2] = evt[2] | ((op inside {OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW}) & m[3]);
		i_core.issue(op, a, b, to);
		#1;
		chk({24'h0, flags}, {24'h0, m[7:0]}, "flags");
		chk({24'h0, alu_result}, {24'h0, m[15:8]}, "result");
		chk({31'h0, irq}, {31'h0, |(evt & en)}, "irq");
		ef = m[7:0];
	endtask : step

	// Holds each channel until its own handshake edge; bready and rready stay up until the answer
	task automatic axi(input logic w, input logic [3:0] ad, input logic [31:0] d, input logic [31:0] ed,
		input logic [1:0] er);
		logic ta, tw, tr, done;
		int   n;
		n    = 0;
		done = 1'b0;
		@(posedge aclk);
		if (w) begin
			awaddr  <= ad;
			wdata   <= d;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
		end else begin
			araddr  <= ad;
			arvalid <= 1'b1;
			rready  <= 1'b1;
		end
		while (!done && n < 50) begin
			#1;
			ta   = awvalid && (awready === 1'b1);
			tw   = wvalid && (wready === 1'b1);
			tr   = arvalid && (arready === 1'b1);
			done = w ? (bvalid === 1'b1) : (rvalid === 1'b1);
			rd   = w ? ed : rdata;
			rs   = w ? bresp : rresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tr)
				arvalid <= 1'b0;
			if (done) begin
				bready <= 1'b0;
				rready <= 1'b0;
			end
			n++;
		end
		chk({31'h0, done}, 32'h1, "bus answer");
		chk(rd, ed, "read data");
		chk({30'h0, rs}, {30'h0, er}, "response");
		#1;
		if (w && ad == REG_FLAGS && er == RESP_OKAY) begin
			ef = (ef & ~SW_MASK) | (d[7:0] & SW_MASK);
			chk({24'h0, flags}, {24'h0, ef}, "flags after write");
		end
	endtask : axi

	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		end_of_test;
	end

	initial begin
		ef  = FLAGS_RST;
		evt = EVT_RST;
		en  = 3'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk({24'h0, flags}, 32'h0, "reset flags");
		axi(1'b0, REG_FLAGS, 32'h0, 32'h0, RESP_OKAY);
		axi(1'b0, REG_EVT_ST, 32'h0, 32'h0, RESP_OKAY);
		axi(1'b0, REG_EVT_EN, 32'h0, 32'h0, RESP_OKAY);
		$display("test reset done");
		for (int i = 0; i < 9; i++)
			step(dop[i], da[i], db[i], 1'b0);
		step(OP_HALT, 8'h00, 8'h00, 1'b1);
		axi(1'b1, REG_FLAGS, 32'h0, 32'h0, RESP_OKAY);
		axi(1'b1, REG_FLAGS, 32'hFF, 32'h0, RESP_OKAY);
		axi(1'b0, REG_FLAGS, 32'h0, {24'h0, ef}, RESP_OKAY);
		step(OP_WATCHDOG_CLEAR, 8'h00, 8'h00, 1'b0);
		$display("test directed done");
		// Random traffic with a watchdog event about one in eight
		for (int i = 0; i < 60; i++)
			step(opt[rnd() % 12], rnd() & 8'hFF, rnd() & 8'hFF, (rnd() % 8) == 0);
		step(OP_HALT, 8'h3C, 8'h00, 1'b0);
		$display("test random done");
		axi(1'b1, REG_EVT_EN, 32'h7, 32'h0, RESP_OKAY);
		en = 3'h7;
		axi(1'b0, REG_EVT_ST, 32'h0, {29'h0, evt}, RESP_OKAY);
		chk({31'h0, irq}, {31'h0, |evt}, "irq enabled");
		axi(1'b1, REG_EVT_CLR, 32'h7, 32'h0, RESP_OKAY);
		evt = 3'h0;
		axi(1'b0, REG_EVT_CLR, 32'h0, 32'h0, RESP_OKAY);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		axi(1'b1, REG_EVT_EN, 32'h2, 32'h0, RESP_OKAY);
		en = 3'h2;
		step(OP_NOP, 8'h00, 8'h00, 1'b1);
		step(OP_HALT, 8'h00, 8'h00, 1'b0);
		axi(1'b0, 4'h2, 32'h0, 32'h0, RESP_SLVERR);
		axi(1'b1, 4'h6, 32'h5, 32'h0, RESP_SLVERR);
		axi(1'b0, REG_EVT_EN, 32'h0, 32'h2, RESP_OKAY);
		$display("test events done");
		end_of_test;
	end
endmodule : tb
`default_nettype wire
